//--- rtl/serial_channel_regs.svh
`ifndef SERIAL_CHANNEL_REGS_SVH
`define SERIAL_CHANNEL_REGS_SVH
// ==========================================================================
// register offsets on the plain register port
`define ADDR_SHIFT_WORD   8'h00
`define ADDR_OWN_ADDRESS  8'h01
`define ADDR_MODE         8'h02
`define ADDR_BUS_CONTROL  8'h03
`define ADDR_INT_TIMING   8'h04
`define ADDR_CLOCK_SELECT 8'h05
`define ADDR_DIRECT_CTRL  8'h06
// ==========================================================================
// serial mode register fields
`define MODE_EN_BIT       7
`define MODE_MATCH_BIT    6
`define MODE_WAKE_BIT     5
`define MODE_SEL_HI       4
`define MODE_SEL_LO       2
`define MODE_SRC_HI       1
`define MODE_SRC_LO       0
`define MODE_SEL_SBI      2'b10
`define MODE_SEL_TWO_WIRE 2'b11
`define SRC_TIMER         2'b10
`define SRC_INTERNAL      2'b11
// ==========================================================================
// bus control, interrupt timing and direct control fields
`define BUS_BUSYEN_BIT    7
`define BUS_CMD_BIT       3
`define BUS_REL_BIT       2
`define ITR_SRC_BIT       5
`define ITR_MASK_BIT      4
`define DIR_CLK_BIT       0
`define DIR_LATCH_BIT     1
`define DIR_ACTIVE_BIT    7
// ==========================================================================
// reset values and counts
`define MODE_RESET        8'h00
`define CLKSEL_RESET      8'h88
`define CLKSEL_MIN        4'h6
`define CLKSEL_MAX        4'hd
`define BITS_PER_WORD     4'h8
`define LAST_BIT_INDEX    4'h7
`endif

//--- rtl/serial_channel_pkg.sv
`default_nettype none
package serial_channel_pkg;
  // ========================================================================
  // word classification on the addressed bus
  typedef enum logic [1:0] {kind_address, kind_command, kind_data} word_kind_t;

  // ========================================================================
  // whole state of the channel
  typedef struct packed {
    logic       sck_s1, sck_s2, sck_s3;
    logic       a_s1, a_s2, a_s3;
    logic       b_s1, b_s2, b_s3;
    logic       si_s1, si_s2;
    logic [7:0] shift;
    logic [7:0] own_addr;
    logic       en, wake;
    logic [2:0] mode_sel;
    logic [1:0] src;
    logic       match;
    logic       busy_en, busy_active, release_flag, command_flag;
    logic       int_src, addr_mask;
    logic [7:0] clk_sel;
    logic       sw_clk, out_latch;
    logic       active;
    logic [3:0] bit_cnt;
    logic       sclk;
    logic [7:0] div_cnt;
    word_kind_t kind;
    logic [7:0] rdata;
    logic       irq;
  } state_t;
endpackage
`default_nettype wire

//--- rtl/multimode_serial_channel.sv
`include "serial_channel_regs.svh"
`default_nettype none
module multimode_serial_channel
  import serial_channel_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  input  wire logic       timer_two_tick,
  input  wire logic       serial_clock_pin_in,
  output logic            serial_clock_pin_out,
  output logic            serial_clock_pin_oe,
  input  wire logic       serial_in_pin,
  output logic            serial_out_pin,
  output logic            serial_out_pin_oe,
  input  wire logic       shared_data_line_a_in,
  output logic            shared_data_line_a_out,
  output logic            shared_data_line_a_oe,
  input  wire logic       shared_data_line_b_in,
  output logic            shared_data_line_b_out,
  output logic            shared_data_line_b_oe,
  output logic            transfer_interrupt
);

  // ========================================================================
  // decoded views of the current state
  state_t     st_r;
  state_t     st_nxt;
  logic       three_wire;
  logic       addressed_bus_mode;
  logic       two_wire;
  logic       line_a_sel;
  logic       master;
  logic [7:0] div_mask;
  logic       tick;
  logic       rise_ev;
  logic       fall_ev;
  logic       din;
  logic       msb_first;
  logic [7:0] new_shift;
  logic       word_end;
  logic       addr_hit;
  logic       line_lvl;
  logic       line_prev;
  logic       wr_shift;
  logic       wakeup_on;
  logic       sclk_lvl;
  logic       data_lvl;

  // mode decode; stopped mode overrides all of them
  assign three_wire = st_r.en && !st_r.mode_sel[2];
  assign addressed_bus_mode        = st_r.en && (st_r.mode_sel[2:1] == `MODE_SEL_SBI);
  assign two_wire   = st_r.en && (st_r.mode_sel[2:1] == `MODE_SEL_TWO_WIRE);
  assign line_a_sel = st_r.mode_sel[0];
  assign msb_first  = !(three_wire && st_r.mode_sel[0]);
  assign master     = st_r.src[1];
  assign wakeup_on  = addressed_bus_mode && st_r.wake && !st_r.int_src;

  // divider mask from the clock select code; illegal codes fall to slowest
  always_comb
  begin
    if (st_r.clk_sel[3:0] < `CLKSEL_MIN || st_r.clk_sel[3:0] > `CLKSEL_MAX)
      div_mask = 8'h7f;
    else
      div_mask = 8'((9'h001 << (st_r.clk_sel[3:0] - `CLKSEL_MIN)) - 9'h001);
  end

  // clock source select, gated by the channel enable
  always_comb
  begin
    if (st_r.src == `SRC_TIMER)
      tick = timer_two_tick;
    else
      tick = ((st_r.div_cnt & div_mask) == div_mask);
    tick = tick && st_r.en && master;
  end

  // serial clock edges: own generator when master, synced pin otherwise
  always_comb
  begin
    if (master)
    begin
      rise_ev = st_r.active && tick && !st_r.sclk;
      fall_ev = st_r.active && tick && st_r.sclk;
    end
    else
    begin
      rise_ev = st_r.active && st_r.sck_s2 && !st_r.sck_s3;
      fall_ev = st_r.active && !st_r.sck_s2 && st_r.sck_s3;
    end
  end

  // data input and the level of the selected shared line
  assign line_lvl  = line_a_sel ? st_r.a_s2 : st_r.b_s2;
  assign line_prev = line_a_sel ? st_r.a_s3 : st_r.b_s3;
  assign din       = three_wire ? st_r.si_s2 : line_lvl;
  assign new_shift = msb_first ? {st_r.shift[6:0], din} : {din, st_r.shift[7:1]};
  assign word_end  = rise_ev && (st_r.bit_cnt == `LAST_BIT_INDEX);
  assign wr_shift  = reg_write && (reg_addr == `ADDR_SHIFT_WORD);

  // comparator, optionally ignoring the lowest bit
  always_comb
  begin
    if (st_r.addr_mask)
      addr_hit = (new_shift[7:1] == st_r.own_addr[7:1]);
    else
      addr_hit = (new_shift == st_r.own_addr);
  end

  // ========================================================================
  // next state
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.irq = 1'b0;
    // two-flop synchronisers for every pin input
    st_nxt.sck_s1 = serial_clock_pin_in;
    st_nxt.sck_s2 = st_r.sck_s1;
    st_nxt.sck_s3 = st_r.sck_s2;
    st_nxt.a_s1   = shared_data_line_a_in;
    st_nxt.a_s2   = st_r.a_s1;
    st_nxt.a_s3   = st_r.a_s2;
    st_nxt.b_s1   = shared_data_line_b_in;
    st_nxt.b_s2   = st_r.b_s1;
    st_nxt.b_s3   = st_r.b_s2;
    st_nxt.si_s1  = serial_in_pin;
    st_nxt.si_s2  = st_r.si_s1;
    // divider runs only while enabled as master; saves power when stopped
    if (st_r.en && master)
      st_nxt.div_cnt = st_r.div_cnt + 8'h01;
    else
      st_nxt.div_cnt = 8'h00;

    // register reads, answer in the next cycle
    st_nxt.rdata = 8'h00;
    if (reg_read)
    begin
      unique case (reg_addr)
        `ADDR_SHIFT_WORD:   st_nxt.rdata = st_r.shift;
        `ADDR_OWN_ADDRESS:  st_nxt.rdata = st_r.own_addr;
        `ADDR_MODE:         st_nxt.rdata = {st_r.en, st_r.match, st_r.wake, st_r.mode_sel, st_r.src};
        `ADDR_BUS_CONTROL:  st_nxt.rdata = {st_r.busy_en, 3'h0, st_r.command_flag, st_r.release_flag, 2'h0};
        `ADDR_INT_TIMING:   st_nxt.rdata = {2'h0, st_r.int_src, st_r.addr_mask, 4'h0};
        `ADDR_CLOCK_SELECT: st_nxt.rdata = st_r.clk_sel;
        `ADDR_DIRECT_CTRL:  st_nxt.rdata = {st_r.active, 5'h00, st_r.out_latch, st_r.sw_clk};
        default:            st_nxt.rdata = 8'h00;
      endcase
    end

    // register writes; hardware events below take priority over them
    if (reg_write)
    begin
      unique case (reg_addr)
        `ADDR_SHIFT_WORD:
        begin
          st_nxt.shift = reg_wdata;
          if (st_r.en)
          begin
            st_nxt.active      = 1'b1;
            st_nxt.bit_cnt     = 4'h0;
            st_nxt.sclk        = 1'b1;
            st_nxt.busy_active = 1'b0;
            st_nxt.out_latch   = msb_first ? reg_wdata[7] : reg_wdata[0];
          end
        end
        `ADDR_OWN_ADDRESS:  st_nxt.own_addr = reg_wdata;
        `ADDR_MODE:
        begin
          st_nxt.en       = reg_wdata[`MODE_EN_BIT];
          st_nxt.wake     = reg_wdata[`MODE_WAKE_BIT];
          st_nxt.mode_sel = reg_wdata[`MODE_SEL_HI:`MODE_SEL_LO];
          st_nxt.src      = reg_wdata[`MODE_SRC_HI:`MODE_SRC_LO];
        end
        `ADDR_BUS_CONTROL:  st_nxt.busy_en = reg_wdata[`BUS_BUSYEN_BIT];
        `ADDR_INT_TIMING:
        begin
          st_nxt.int_src   = reg_wdata[`ITR_SRC_BIT];
          st_nxt.addr_mask = reg_wdata[`ITR_MASK_BIT];
        end
        `ADDR_CLOCK_SELECT: st_nxt.clk_sel = reg_wdata;
        `ADDR_DIRECT_CTRL:
        begin
          st_nxt.sw_clk    = reg_wdata[`DIR_CLK_BIT];
          st_nxt.out_latch = reg_wdata[`DIR_LATCH_BIT];
        end
        default:
        begin
        end
      endcase
    end

    // serial clock generator and shifting
    if (st_r.active && master && tick)
      st_nxt.sclk = !st_r.sclk;
    if (fall_ev && st_r.bit_cnt != 4'h0)
      st_nxt.out_latch = msb_first ? st_r.shift[7] : st_r.shift[0];
    if (rise_ev)
    begin
      st_nxt.shift   = new_shift;
      st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
    end

    // end of word: interrupt, classification, match and busy
    if (word_end)
    begin
      st_nxt.active = 1'b0;
      st_nxt.sclk   = 1'b1;
      if (!wakeup_on)
        st_nxt.irq = 1'b1;
      if (addressed_bus_mode)
      begin
        st_nxt.out_latch = 1'b1;
        st_nxt.busy_active = st_r.busy_en;
        st_nxt.kind = kind_data;
        if (st_r.kind == kind_address)
        begin
          st_nxt.match = addr_hit;
          if (!addr_hit)
            st_nxt.release_flag = 1'b0;
          if (wakeup_on && addr_hit)
            st_nxt.irq = 1'b1;
        end
      end
    end

    // bus release and command triggers: data edges while the clock is high
    if (addressed_bus_mode && !st_r.active && st_r.sck_s2 && st_r.sck_s3)
    begin
      if (line_lvl && !line_prev)
      begin
        st_nxt.release_flag = 1'b1;
        st_nxt.command_flag = 1'b0;
        st_nxt.kind         = kind_address;
        st_nxt.match        = 1'b0;
        if (st_r.int_src)
          st_nxt.irq = 1'b1;
      end
      else if (!line_lvl && line_prev)
      begin
        st_nxt.command_flag = 1'b1;
        st_nxt.kind         = kind_command;
      end
    end

    // stopped mode halts everything; busy never survives outside the bus mode
    if (!st_r.en)
      st_nxt.active = 1'b0;
    if (!addressed_bus_mode)
      st_nxt.busy_active = 1'b0;

    // sync reset; shift word and own address keep whatever they hold
    if (rst)
    begin
      st_nxt              = '0;
      st_nxt.shift        = st_r.shift;
      st_nxt.own_addr     = st_r.own_addr;
      st_nxt.clk_sel      = `CLKSEL_RESET;
      st_nxt.sclk         = 1'b1;
      st_nxt.sw_clk       = 1'b1;
      st_nxt.out_latch    = 1'b1;
      st_nxt.kind         = kind_address;
      {st_nxt.en, st_nxt.match, st_nxt.wake, st_nxt.mode_sel, st_nxt.src} = `MODE_RESET;
    end
  end

  always_ff @(posedge core_clk)
  begin
    st_r <= st_nxt;
  end

  // ========================================================================
  // pin drive
  assign sclk_lvl = st_r.sclk && st_r.sw_clk;
  assign data_lvl = st_r.out_latch && !st_r.busy_active;

  always_comb
  begin
    serial_clock_pin_out   = 1'b0;
    serial_clock_pin_oe    = 1'b0;
    shared_data_line_a_out = 1'b0;
    shared_data_line_a_oe  = 1'b0;
    shared_data_line_b_out = 1'b0;
    shared_data_line_b_oe  = 1'b0;
    // open-drain clock in two-wire, push-pull elsewhere when master
    if (two_wire)
      serial_clock_pin_oe = !sclk_lvl;
    else if (st_r.en && master)
    begin
      serial_clock_pin_out = sclk_lvl;
      serial_clock_pin_oe  = 1'b1;
    end
    // shared lines are open drain: only a low level is driven
    if (addressed_bus_mode || two_wire)
    begin
      if (line_a_sel)
        shared_data_line_a_oe = !data_lvl;
      else
        shared_data_line_b_oe = !data_lvl;
    end
  end

  assign serial_out_pin     = st_r.out_latch;
  assign serial_out_pin_oe  = three_wire;
  assign reg_rdata          = st_r.rdata;
  assign transfer_interrupt = st_r.irq;

  // ========================================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_start;
    wr_shift && st_r.en |=> st_r.active && st_r.bit_cnt == 4'h0;
  endproperty
  a_start: assert property (p_start) else $error("write did not start transfer");

  property p_stopped;
    !st_r.en |=> !st_r.active && st_r.div_cnt == 8'h00;
  endproperty
  a_stopped: assert property (p_stopped) else $error("stopped channel is active");

  property p_busy_clear;
    wr_shift && st_r.en && addressed_bus_mode |=> !st_r.busy_active && st_r.busy_en == $past(st_r.busy_en);
  endproperty
  a_busy_clear: assert property (p_busy_clear) else $error("busy not ended by write");

  property p_word_end;
    word_end |=> !st_r.active && st_r.bit_cnt == `BITS_PER_WORD;
  endproperty
  a_word_end: assert property (p_word_end) else $error("word not ended after eight clocks");

  property p_irq_plain;
    word_end && (three_wire || two_wire) |=> transfer_interrupt ##1 !transfer_interrupt;
  endproperty
  a_irq_plain: assert property (p_irq_plain) else $error("missing word interrupt");

  property p_match;
    word_end && addressed_bus_mode && st_r.kind == kind_address |=> st_r.match == $past(addr_hit);
  endproperty
  a_match: assert property (p_match) else $error("match flag wrong");

  property p_mask;
    word_end && addressed_bus_mode && st_r.kind == kind_address && st_r.addr_mask && new_shift[7:1] == st_r.own_addr[7:1] |=> st_r.match;
  endproperty
  a_mask: assert property (p_mask) else $error("masked compare failed");

  property p_release_clear;
    word_end && addressed_bus_mode && st_r.kind == kind_address && !addr_hit |=> !st_r.release_flag;
  endproperty
  a_release_clear: assert property (p_release_clear) else $error("release flag kept");

  property p_wakeup;
    word_end && wakeup_on && !(st_r.kind == kind_address && addr_hit) |=> !transfer_interrupt;
  endproperty
  a_wakeup: assert property (p_wakeup) else $error("wakeup interrupt without match");

  property p_latch;
    word_end && addressed_bus_mode |=> st_r.out_latch;
  endproperty
  a_latch: assert property (p_latch) else $error("latch not set after word");

  property p_busy_mode;
    !addressed_bus_mode |=> !st_r.busy_active;
  endproperty
  a_busy_mode: assert property (p_busy_mode) else $error("busy outside bus mode");

endmodule
`default_nettype wire

//--- tb/serial_peer_model.sv
`default_nettype none
// ==========================================================================
// three-wire peripheral on the far side: shifts on the clock it is given
module serial_peer_model
(
  input  wire logic       clk,
  input  wire logic       sclk,
  input  wire logic       sdo,
  input  wire logic       lsb_first,
  input  wire logic       load,
  input  wire logic [7:0] tx_byte,
  output logic            sdi,
  output logic      [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       sclk_q = 1'b1;
  logic [2:0] cnt    = 3'h0;
  logic [7:0] tx     = 8'h00;
  initial sdi = 1'b0;
  initial rx_byte = 8'h00;

  // edges seen one core cycle late, well inside each half period
  always @(posedge clk)
  begin
    sclk_q <= sclk;
    if (load)
    begin
      tx  <= tx_byte;
      cnt <= 3'h0;
    end
    else if (sclk_q && !sclk)
    begin
      sdi <= lsb_first ? tx[cnt] : tx[3'h7 - cnt];
      cnt <= cnt + 3'h1;
    end
    else if (!sclk_q && sclk)
    begin
      rx_byte <= lsb_first ? {sdo, rx_byte[7:1]} : {rx_byte[6:0], sdo};
      // after the last bit the line no longer holds a valid level
      if (cnt == 3'h0)
        sdi <= ~sdi;
    end
  end
endmodule
`default_nettype wire

//--- tb/tb.sv
`include "serial_channel_regs.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk, rst, reg_write, reg_read, timer_two_tick, load, lsb;
  logic [7:0] reg_addr, reg_wdata, tx_byte;
  logic [7:0] reg_rdata, peer_rx;
  logic       sck_out, sck_oe, so, so_oe, a_out, a_oe, b_out, b_oe, irq, peer_sdi;
  logic       sck_in, a_in, b_in;
  int         n_errors, samples_checked;

`define CHECK(act, exp) begin samples_checked++; if ((act) !== (exp)) begin n_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, (act), (exp)); end end

  // ==========================================================================
  // open-drain and pulled-up wires resolved from every driver
  assign sck_in = sck_oe ? sck_out : 1'b1;
  assign a_in   = a_oe ? a_out : 1'b1;
  assign b_in   = b_oe ? b_out : 1'b1;

  multimode_serial_channel dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .timer_two_tick(timer_two_tick),
    .serial_clock_pin_in(sck_in), .serial_clock_pin_out(sck_out), .serial_clock_pin_oe(sck_oe),
    .serial_in_pin(peer_sdi), .serial_out_pin(so), .serial_out_pin_oe(so_oe),
    .shared_data_line_a_in(a_in), .shared_data_line_a_out(a_out), .shared_data_line_a_oe(a_oe),
    .shared_data_line_b_in(b_in), .shared_data_line_b_out(b_out), .shared_data_line_b_oe(b_oe),
    .transfer_interrupt(irq));

  serial_peer_model peer (.clk(core_clk), .sclk(sck_in), .sdo(so), .lsb_first(lsb), .load(load),
    .tx_byte(tx_byte), .sdi(peer_sdi), .rx_byte(peer_rx));

  // ==========================================================================
  // clock, reset and register port tasks
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // counts rising serial clocks until the interrupt pulse, bounded
  task automatic wait_word(input int limit, output int rises, output logic got);
    logic prev;
    rises = 0;
    got   = 1'b0;
    prev  = sck_in;
    repeat (limit)
    begin
      @(posedge core_clk);
      #1;
      if (!prev && sck_in)
        rises++;
      prev = sck_in;
      if (irq === 1'b1)
      begin
        got = 1'b1;
        return;
      end
    end
  endtask

  // ==========================================================================
  // scenarios
  task automatic test_reset;
    logic [7:0] d;
    rd(`ADDR_MODE, d);
    `CHECK(d, 8'h00)
    rd(`ADDR_CLOCK_SELECT, d);
    `CHECK(d, 8'h88)
    rd(8'h07, d);
    `CHECK(d, 8'h00)
    `CHECK({sck_oe, so_oe, a_oe, b_oe, irq}, 5'h00)
    $display("test reset done");
  endtask

  // a shift write while stopped only stores the word
  task automatic test_stopped;
    logic [7:0] d;
    int         r;
    logic       got;
    wr(`ADDR_SHIFT_WORD, 8'h3c);
    wait_word(60, r, got);
    `CHECK(got, 1'b0)
    `CHECK(r, 0)
    rd(`ADDR_SHIFT_WORD, d);
    `CHECK(d, 8'h3c)
    $display("test stopped done");
  endtask

  // one full word; three-wire checks the peer, bus and two-wire modes loop back on the selected line a or b
  task automatic xfer(input logic [7:0] mode, input logic [7:0] w, input logic [7:0] pb,
                      input logic l, input logic three, input logic [7:0] em);
    logic [7:0] d;
    int         r;
    logic       got;
    wr(`ADDR_CLOCK_SELECT, 8'h89);
    wr(`ADDR_MODE, mode);
    @(posedge core_clk);
    tx_byte <= pb;
    lsb     <= l;
    load    <= 1'b1;
    @(posedge core_clk);
    load <= 1'b0;
    wr(`ADDR_OWN_ADDRESS, w);
    wr(`ADDR_SHIFT_WORD, w);
    wait_word(600, r, got);
    if (!got)
    begin
      $display("unexpected at %0t: got %h expected %h", $time, got, 1'b1);
      n_errors++;
      test_done();
    end
    `CHECK(r, 8)
    @(posedge core_clk);
    #1;
    `CHECK(irq, 1'b0)
    `CHECK(sck_in, 1'b1)
    if (three)
    begin
      `CHECK(peer_rx, w)
      `CHECK(sck_oe, 1'b1)
      `CHECK(so_oe, 1'b1)
    end
    else
    begin
      `CHECK(b_oe, 1'b0)
      `CHECK(a_oe, 1'b0)
    end
    rd(`ADDR_SHIFT_WORD, d);
    `CHECK(d, three ? pb : w)
    rd(`ADDR_MODE, d);
    `CHECK(d, em)
    wr(`ADDR_MODE, 8'h00);
    $display("test transfer mode %h done", mode);
  endtask

  initial
  begin
    rst = 1'b1;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    timer_two_tick = 1'b0;
    load = 1'b0;
    lsb = 1'b0;
    tx_byte = 8'h00;
    n_errors = 0;
    samples_checked = 0;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    test_reset();
    test_stopped();
    xfer(8'h83, 8'ha6, 8'h5b, 1'b0, 1'b1, 8'h83);
    xfer(8'h87, 8'h4c, 8'h1e, 1'b1, 1'b1, 8'h87);
    xfer(8'h9f, 8'h3b, 8'h00, 1'b0, 1'b0, 8'h9f);
    xfer(8'h93, 8'ha5, 8'hff, 1'b0, 1'b0, 8'hd3);
    xfer(8'h93, 8'h5a, 8'h00, 1'b0, 1'b0, 8'hd3);
    xfer(8'h97, 8'hff, 8'h00, 1'b0, 1'b0, 8'hd7);
    test_done();
  end
endmodule
`default_nettype wire
